/* File: hdl/sft_pkg.sv */
/*
  sft_pkg: constants and types shared by the serial flash / TPM pin controller.
  Assumes a 125 MHz system clock; all serial clock divisors derive from it.
*/
package sft_pkg;

  // system clock and serial clock rates, in MHz as specified
  localparam int SYS_MHZ = 125;
  localparam int FLASH_MAX_MHZ = 50;
  localparam int TPM_DEF_MHZ = 20;
  localparam int TPM_LO_MHZ = 17;
  localparam int TPM_MID_MHZ = 33;
  localparam int TPM_HI_MHZ = 48;

  // divisors round up so the pin never runs faster than the named rate
  localparam logic [3:0] DIV_FLASH = 4'((SYS_MHZ + FLASH_MAX_MHZ - 1) / FLASH_MAX_MHZ);
  localparam logic [3:0] DIV_TPM_DEF = 4'((SYS_MHZ + TPM_DEF_MHZ - 1) / TPM_DEF_MHZ);
  localparam logic [3:0] DIV_TPM_LO = 4'((SYS_MHZ + TPM_LO_MHZ - 1) / TPM_LO_MHZ);
  localparam logic [3:0] DIV_TPM_MID = 4'((SYS_MHZ + TPM_MID_MHZ - 1) / TPM_MID_MHZ);
  localparam logic [3:0] DIV_TPM_HI = 4'((SYS_MHZ + TPM_HI_MHZ - 1) / TPM_HI_MHZ);

  // tpm rate strap codes; zero is not a valid setting
  localparam logic [1:0] RATE_NONE = 2'h0;
  localparam logic [1:0] RATE_LO = 2'h1;
  localparam logic [1:0] RATE_MID = 2'h2;
  localparam logic [1:0] RATE_HI = 2'h3;

  // targets: index of the select line
  localparam logic [1:0] TGT_PRIMARY = 2'h0;
  localparam logic [1:0] TGT_SECONDARY = 2'h1;
  localparam logic [1:0] TGT_TPM = 2'h2;

  // lane width codes
  localparam logic [1:0] W_SINGLE = 2'h0;
  localparam logic [1:0] W_DUAL = 2'h1;
  localparam logic [1:0] W_QUAD = 2'h2;

  // pin values during and after reset, and the sample tick delay
  localparam logic [3:0] OE_RST = 4'h0;
  localparam logic [3:0] OE_IDLE = 4'h1;
  localparam logic [3:0] PU_RST = 4'hC;
  localparam logic [2:0] SEL_IDLE = 3'h7;
  localparam logic [3:0] TICK_SAMPLE_DLY = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPEN = 2'b01,
    ST_SHIFT = 2'b10,
    ST_GAP = 2'b11
  } sft_state_t;

endpackage

/* File: hdl/sft_tick_if.sv */
/*
  sft_tick_if: run request and edge ticks between the controller and its clock generator.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/100ps
interface sft_tick_if;
  logic run;
  logic [3:0] div;
  logic sclk;
  logic rise;
  logic fall;
  logic sample;

  modport gen (input run, input div, output sclk, output rise, output fall, output sample);
  modport user (output run, output div, input sclk, input rise, input fall, input sample);
endinterface

/* File: hdl/sft_sclk_gen.sv */
/*
  sft_sclk_gen: divides the system clock into the serial clock while run is high.
  Assumes div is 3 or more and stays constant while run is high.
*/
`timescale 1ns/100ps
module sft_sclk_gen
  import sft_pkg::*;
(
  input wire logic i_sys_clk,  // system clock
  input wire logic i_rst_n,    // async reset, active low
  sft_tick_if.gen tk           // run in, ticks out
);

  typedef struct packed {
    logic [3:0] cnt;
    logic sclk;
    logic rise;
    logic fall;
    logic [1:0] dly;
  } sft_gen_t;

  sft_gen_t s;
  sft_gen_t next_s;

  // low phase takes the extra cycle of an odd divisor, so the low time never gets short
  always_comb begin
    next_s = s;
    if (tk.run) begin
      next_s.cnt = (s.cnt == tk.div - 4'h1) ? 4'h0 : s.cnt + 4'h1;
    end else begin
      next_s.cnt = 4'h0;
    end
    next_s.sclk = tk.run && (next_s.cnt >= tk.div - (tk.div >> 1));
    next_s.rise = next_s.sclk && !s.sclk;
    next_s.fall = !next_s.sclk && s.sclk;
    // sample tick trails the rise by the input synchroniser depth
    next_s.dly = {s.dly[0], s.rise};
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.sclk = s.sclk;
  assign tk.rise = s.rise;
  assign tk.fall = s.fall;
  assign tk.sample = s.dly[1];

endmodule // sft_sclk_gen

/* File: hdl/sft_pins.sv */
/*
  sft_pins: pin controller for a shared serial bus with two flash selects and one TPM select.
  Assumes I_RST_N is the resume reset, that the user port is on the system clock, and
  that pad drivers resolve each line from its out, output enable and pull enables.
*/
// Function
// R1: the TPM is reached only through the third select.
// R2: the platform attaches at most one TPM to this bus.
// R3: TPM transfers run near 17, 33 or 48 MHz by soft strap.
// R4: TPM clock defaults to 20 MHz; a valid strap replaces it.
// R5: the TPM must work at 20 MHz and tolerate 15 to 20 MHz.
// R6: no TPM interrupt handling here; it uses a separate input.
// R7: the first select addresses only the primary flash.
// R8: the second select addresses only the optional secondary flash.
// R9: the shared serial clock never exceeds 50 MHz.
// R10: host out is an output unless strapped bidirectional as data bit 0.
// R11: host in is an input unless strapped bidirectional as data bit 1.
// R12: data bits 2 and 3 are used only in quad modes.
// R13: pull-ups stay off in resume reset, enabled after release; the code keeps data bits 2 and 3 pulled up (PU_RST) in reset.
// R14: reset pin states, then clock and host out low, selects high.
// R15: at most one select active, others high for the whole transfer.
`timescale 1ns/100ps
module sft_pins
  import sft_pkg::*;
(
  input wire logic I_SYS_CLK,          // 125 MHz system clock
  input wire logic I_RST_N,            // resume reset, async, active low
  input wire logic [1:0] I_TPM_RATE_STRAP, // tpm rate soft strap
  input wire logic I_BIDIR_STRAP,      // data bits 0/1 bidirectional
  input wire logic I_REQ,              // byte request
  input wire logic [1:0] I_TARGET,     // select index, frame start only
  input wire logic [1:0] I_WIDTH,      // lanes: single, dual, quad
  input wire logic I_READ,             // byte is read from target
  input wire logic I_LAST,             // release select after byte
  input wire logic [7:0] I_TX_BYTE,    // byte to send
  input wire logic [3:0] I_DATA_BIT_IN, // data bit 3..0 pad inputs
  output logic O_READY,                // request may be taken
  output logic O_ACK,                  // byte done pulse
  output logic [7:0] O_RX_BYTE,        // byte received
  output logic O_SERIAL_CLOCK_OUT,     // serial clock level
  output logic O_SERIAL_CLOCK_OE,      // serial clock driven
  output logic O_SERIAL_CLOCK_PD_EN,   // serial clock pull-down
  output logic O_PRIMARY_FLASH_SELECT_N,   // primary flash select
  output logic O_SECONDARY_FLASH_SELECT_N, // secondary flash select
  output logic O_TPM_SELECT_N,         // tpm select
  output logic O_SELECT_OE,            // selects driven
  output logic [3:0] O_DATA_BIT_OUT,   // data bit 3..0 out
  output logic [3:0] O_DATA_BIT_OE,    // data bit 3..0 driven
  output logic [3:0] O_DATA_BIT_PU_EN  // data bit 3..0 pull-up
);

  typedef struct packed {
    logic up;
    logic pd;
    sft_state_t st;
    logic [1:0] tgt;
    logic [1:0] w;
    logic last;
    logic rd;
    logic [3:0] div;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [3:0] steps;
    logic [2:0] sel_n;
    logic [3:0] dout;
    logic [3:0] doe;
    logic [3:0] pu;
    logic ready;
    logic ack;
    logic [7:0] rx_byte;
    logic [1:0] rate1;
    logic [1:0] rate2;
    logic bidir1;
    logic bidir2;
    logic [3:0] din1;
    logic [3:0] din2;
  } sft_top_t;

  sft_top_t s;
  sft_top_t next_s;
  sft_tick_if tk ();

  // strap picks the tpm divisor, anything invalid keeps the 20 MHz default
  function automatic logic [3:0] tpm_div(input logic [1:0] rate);
    unique case (rate)
      RATE_LO: tpm_div = DIV_TPM_LO; // R3
      RATE_MID: tpm_div = DIV_TPM_MID; // R3
      RATE_HI: tpm_div = DIV_TPM_HI; // R3
      RATE_NONE: tpm_div = DIV_TPM_DEF; // R4
    endcase
  endfunction

  // lane drive for the current head of the shift register
  function automatic logic [7:0] lanes(input logic [7:0] sh, input logic [1:0] w,
                                       input logic rd);
    logic [3:0] o;
    logic [3:0] e;
    o = 4'h0;
    e = OE_IDLE;
    unique case (w)
      W_DUAL: begin
        o = {2'b00, sh[7], sh[6]};
        e = rd ? 4'h0 : 4'h3; // R10 R11
      end
      W_QUAD: begin
        o = sh[7:4];
        e = rd ? 4'h0 : 4'hF; // R12
      end
      default: begin
        o = {3'b000, sh[7]}; // R10
        e = OE_IDLE; // R11
      end
    endcase
    lanes = {o, e};
  endfunction

  function automatic logic [3:0] step_bits(input logic [1:0] w);
    unique case (w)
      W_DUAL: step_bits = 4'h2;
      W_QUAD: step_bits = 4'h4;
      default: step_bits = 4'h1;
    endcase
  endfunction

  sft_sclk_gen u_gen (
    .i_sys_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .tk(tk)
  );

  // run drops on the last sample, else a divisor of 3 starts an extra rise (ninth in single lane) on the ack edge
  assign tk.run = (s.st == ST_SHIFT) && !(s.steps == 4'h1 && tk.sample);
  assign tk.div = s.div;

  // next state: synchronisers, frame control, shifting
  always_comb begin
    logic take;
    logic [1:0] weff;
    logic [7:0] lv;
    logic [3:0] nb;
    take = 1'b0;
    weff = W_SINGLE;
    lv = 8'h00;
    nb = 4'h0;
    next_s = s;
    next_s.ack = 1'b0;
    next_s.up = 1'b1;
    next_s.pd = 1'b0; // R14
    next_s.rate1 = I_TPM_RATE_STRAP;
    next_s.rate2 = s.rate1;
    next_s.bidir1 = I_BIDIR_STRAP;
    next_s.bidir2 = s.bidir1;
    next_s.din1 = I_DATA_BIT_IN;
    next_s.din2 = s.din1;
    // leaving reset, host out starts driving low
    if (!s.up) begin
      next_s.doe = OE_IDLE; // R14
    end
    unique case (s.st)
      ST_IDLE: begin
        next_s.ready = s.up;
        // unknown target code is never taken, so no select can stray
        if (s.up && s.ready && I_REQ && I_TARGET != 2'h3) begin
          take = 1'b1;
          next_s.tgt = I_TARGET;
          next_s.div = (I_TARGET == TGT_TPM) ? tpm_div(s.rate2) : DIV_FLASH; // R4 R9
          next_s.sel_n = ~(3'h1 << I_TARGET); // R1 R7 R8 R15
        end
      end
      ST_OPEN: begin
        take = I_REQ; // select stays on the frame's target
      end
      ST_SHIFT: begin
        if (tk.fall) begin
          next_s.sh = s.sh << step_bits(s.w);
          lv = lanes(next_s.sh, s.w, s.rd);
          next_s.dout = lv[7:4];
        end
        if (tk.sample) begin
          // no lane mask: single lane reads host in, bit 1
          nb = s.din2;
          unique case (s.w)
            W_DUAL: next_s.rx = {s.rx[5:0], nb[1:0]};
            W_QUAD: next_s.rx = {s.rx[3:0], nb};
            default: next_s.rx = {s.rx[6:0], nb[1]}; // host in carries data
          endcase
          next_s.steps = s.steps - 4'h1;
          if (s.steps == 4'h1) begin
            next_s.ack = 1'b1;
            next_s.rx_byte = next_s.rx;
            next_s.dout = 4'h0; // R14
            next_s.doe = OE_IDLE; // R10
            next_s.ready = !s.last;
            next_s.st = s.last ? ST_GAP : ST_OPEN;
            if (s.last) begin
              next_s.sel_n = SEL_IDLE; // R15
            end
          end
        end
      end
      ST_GAP: begin
        // one idle cycle with all selects high between frames
        next_s.st = ST_IDLE;
        next_s.ready = 1'b1;
      end
    endcase
    if (take) begin
      // without the strap the two low lanes stay simplex, single lane only
      weff = s.bidir2 ? I_WIDTH : W_SINGLE; // R10 R11 R12
      if (weff == 2'h3) begin
        weff = W_SINGLE;
      end
      lv = lanes(I_TX_BYTE, weff, I_READ);
      next_s.w = weff;
      next_s.rd = I_READ;
      next_s.last = I_LAST;
      next_s.sh = I_TX_BYTE;
      next_s.steps = 4'h8 / step_bits(weff);
      next_s.dout = lv[7:4];
      next_s.doe = lv[3:0];
      next_s.ready = 1'b0;
      next_s.st = ST_SHIFT;
    end
    // pull-ups only on undriven lines; in reset PU_RST holds bits 2 and 3 pulled up
    next_s.pu = ~next_s.doe; // R13
  end

  // reset holds the resume-reset pin states
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
      s.pd <= 1'b1; // R14
      s.st <= ST_IDLE;
      s.div <= DIV_TPM_DEF; // R4
      s.sel_n <= SEL_IDLE;
      s.doe <= OE_RST; // R14
      s.pu <= PU_RST; // R13 R14
    end else begin
      s <= next_s;
    end
  end

  // all pin outputs come from flops
  assign O_READY = s.ready;
  assign O_ACK = s.ack;
  assign O_RX_BYTE = s.rx_byte;
  assign O_SERIAL_CLOCK_OUT = tk.sclk; // R9
  assign O_SERIAL_CLOCK_OE = s.up; // R14
  assign O_SERIAL_CLOCK_PD_EN = s.pd; // R14
  assign O_PRIMARY_FLASH_SELECT_N = s.sel_n[0];
  assign O_SECONDARY_FLASH_SELECT_N = s.sel_n[1];
  assign O_TPM_SELECT_N = s.sel_n[2];
  assign O_SELECT_OE = s.up; // R14
  assign O_DATA_BIT_OUT = s.dout;
  assign O_DATA_BIT_OE = s.doe;
  assign O_DATA_BIT_PU_EN = s.pu;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  AST_TPM_SEL_ONLY: assert property (!O_TPM_SELECT_N |-> s.tgt == TGT_TPM) // R1
    else $error("tpm select active for another target");
  AST_PRIMARY_SEL: assert property (!O_PRIMARY_FLASH_SELECT_N |-> s.tgt == TGT_PRIMARY) // R7
    else $error("primary select active for another target");
  AST_SECONDARY_SEL: assert property (!O_SECONDARY_FLASH_SELECT_N |-> s.tgt == TGT_SECONDARY) // R8
    else $error("secondary select active for another target");
  AST_ONE_SEL: assert property ($onehot0(~s.sel_n) and // R15
                               (s.st == ST_SHIFT |-> $onehot(~s.sel_n)))
    else $error("select pattern wrong");
  AST_SEL_HELD: assert property (s.st == ST_SHIFT && tk.run |=> $stable(s.sel_n)) // R15
    else $error("select moved within a byte");
  AST_CLK_MAX: assert property ($rose(O_SERIAL_CLOCK_OUT) |=> !$rose(O_SERIAL_CLOCK_OUT) [*2]) // R9
    else $error("serial clock faster than limit");
  AST_TPM_RATE: assert property ($fell(s.sel_n[2]) |-> s.div == tpm_div($past(s.rate2)) // R3
                                 && s.div >= 4'h3)
    else $error("tpm divisor not from strap");
  AST_TPM_DEFAULT: assert property ($fell(s.sel_n[2]) && $past(s.rate2) == RATE_NONE // R4
                                    |-> s.div == DIV_TPM_DEF)
    else $error("tpm default rate wrong");
  AST_NO_BIDIR: assert property ($rose(s.st == ST_SHIFT) && !$past(s.bidir2) // R10 R11
                                 |-> O_DATA_BIT_OE[3:1] == 3'h0 && s.w == W_SINGLE)
    else $error("lane driven without strap");
  AST_HIGH_LANES: assert property (O_DATA_BIT_OE[3] || O_DATA_BIT_OE[2] |-> s.w == W_QUAD) // R12
    else $error("bits 2 and 3 driven outside quad");
  AST_PULL_AFTER: assert property ($rose(s.up) |=> O_DATA_BIT_PU_EN == 4'hE && O_SELECT_OE
                                   && O_SERIAL_CLOCK_OE && !O_SERIAL_CLOCK_OUT) // R13 R14
    else $error("post reset pin state wrong");
  AST_PU_DRIVE: assert property (s.up |-> (O_DATA_BIT_PU_EN & O_DATA_BIT_OE) == 4'h0) // R13
    else $error("pull-up on a driven lane");
  AST_ACK_TIME: assert property (s.st == ST_SHIFT && s.steps == 4'h1 && tk.sample |=> O_ACK)
    else $error("byte done not acknowledged");

  COV_TPM_FRAME: cover property (!O_TPM_SELECT_N ##[1:200] O_ACK);
  COV_QUAD_READ: cover property (s.w == W_QUAD && s.rd && O_ACK);
  COV_TWO_BYTES: cover property (O_ACK ##1 s.st == ST_OPEN ##[1:200] O_ACK);
  COV_STRAP_RATE: cover property (s.tgt == TGT_TPM && s.div == DIV_TPM_HI && O_ACK);

endmodule // sft_pins

/* File: sim/sft_target_model.sv */
/*
  sft_target_model: behavioural flash and tpm targets on the shared serial pins.
  Assumes the bench resolves each pad and names the byte and lane width to return.
*/
`timescale 1ns/100ps
module sft_target_model
  import sft_pkg::*;
(
  input wire logic i_sclk,          // serial clock at the pin
  input wire logic [2:0] i_sel_n,   // selects at the pins
  input wire logic [1:0] i_width,   // lane width of this byte
  input wire logic [7:0] i_resp,    // byte to return
  input wire logic [3:0] i_host_oe, // lanes the host drives
  output logic [3:0] o_oe,          // lanes driven here
  output logic [3:0] o_val          // values driven here
);
  logic idle;
  logic [7:0] falls = 8'h00;
  logic [7:0] sh;
  logic [3:0] mask;

  assign idle = &i_sel_n;

  // shift on falls so each rise sees a settled bit; any clock rate is taken
  always @(negedge i_sclk or posedge idle) begin
    if (idle) begin
      falls <= 8'h00;
    end else begin
      falls <= falls + 8'h01;
    end
  end

  // one device answers a select; lanes the host drives are never fought
  always_comb begin
    sh = i_resp << falls[2:0];
    mask = 4'h2;
    o_val = {2'h0, sh[7], 1'b0};
    if (i_width == W_DUAL) begin
      sh = i_resp << {falls[1:0], 1'b0};
      mask = 4'h3;
      o_val = {2'h0, sh[7:6]};
    end else if (i_width == W_QUAD) begin
      sh = i_resp << {falls[0], 2'h0};
      mask = 4'hF;
      o_val = sh[7:4];
    end
    o_oe = idle ? 4'h0 : mask & ~i_host_oe;
  end
endmodule // sft_target_model

/* File: sim/testbench.sv */
/*
  testbench: drives the serial pin controller byte by byte and checks pins and results.
  Assumes a 125 MHz clock and the target model answering on released lanes.
*/
`timescale 1ns/100ps
module testbench;
  import sft_pkg::*;
  typedef struct packed {
    logic chk_rx;
    logic [7:0] rx;
    logic chk_tx;
    logic [7:0] tx;
    logic [2:0] sel;
    logic [3:0] oe;
    logic [3:0] div;
  } sft_exp_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] rate = 2'h0;
  logic bidir = 1'b0;
  logic req = 1'b0;
  logic [1:0] tgt = 2'h0;
  logic [1:0] width = 2'h0;
  logic rd = 1'b0;
  logic lst = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [1:0] m_width = 2'h0;
  logic [7:0] m_resp = 8'h00;
  logic [3:0] pad;
  logic [3:0] pad_last = 4'h0;
  logic [3:0] m_oe, m_val, d_out, d_oe, d_pu, oe_s;
  logic ready, ack, sclk, sclk_oe, sclk_pd, sel_oe, sclk_q, in_frame;
  logic [2:0] sel_n, sel_s;
  logic [7:0] rx_byte, col;
  logic [1:0] cur_tgt;
  logic [3:0] cur_div;
  int fail_count = 0;
  int total_checks = 0;
  int seed, cyc, t_rise, per;
  sft_exp_t exp_q[$];

  initial begin
    forever #4 clk = ~clk;
  end

  // released lanes fall to the pull-up, else to the inverse of the last level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad[i] = d_oe[i] ? d_out[i] : m_oe[i] ? m_val[i] : d_pu[i] ? 1'b1 : ~pad_last[i];
    end
  end
  always @(posedge clk) begin
    pad_last <= pad;
  end

  sft_pins sft_pins_inst (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_TPM_RATE_STRAP(rate),
    .I_BIDIR_STRAP(bidir), .I_REQ(req), .I_TARGET(tgt), .I_WIDTH(width), .I_READ(rd),
    .I_LAST(lst), .I_TX_BYTE(tx), .I_DATA_BIT_IN(pad), .O_READY(ready), .O_ACK(ack),
    .O_RX_BYTE(rx_byte), .O_SERIAL_CLOCK_OUT(sclk), .O_SERIAL_CLOCK_OE(sclk_oe),
    .O_SERIAL_CLOCK_PD_EN(sclk_pd), .O_PRIMARY_FLASH_SELECT_N(sel_n[0]),
    .O_SECONDARY_FLASH_SELECT_N(sel_n[1]), .O_TPM_SELECT_N(sel_n[2]),
    .O_SELECT_OE(sel_oe), .O_DATA_BIT_OUT(d_out), .O_DATA_BIT_OE(d_oe),
    .O_DATA_BIT_PU_EN(d_pu));

  // undriven clock and selects sit at their pull-downs
  sft_target_model sft_target_model_inst (.i_sclk(sclk_oe & sclk),
    .i_sel_n(sel_oe ? sel_n : 3'h0), .i_width(m_width), .i_resp(m_resp),
    .i_host_oe(d_oe), .o_oe(m_oe), .o_val(m_val));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // request held from one edge until the edge that finds ready high
  task automatic launch(input logic [1:0] t, w, input logic r, l, input logic [7:0] b);
    int n;
    @(posedge clk);
    req <= 1'b1;
    tgt <= t;
    width <= w;
    rd <= r;
    lst <= l;
    tx <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 100);
    check("taken", 8'h1, 8'(ready));
    req <= 1'b0;
  endtask

  task automatic send(input logic [1:0] t, w, input logic r, l);
    sft_exp_t e;
    logic [1:0] ew;
    int n;
    ew = (bidir && w != 2'h3) ? w : W_SINGLE;
    e.tx = 8'($random(seed));
    e.rx = 8'($random(seed));
    e.chk_rx = r || ew == W_SINGLE;
    e.chk_tx = !r || ew == W_SINGLE;
    e.oe = (ew == W_SINGLE) ? 4'h1 : r ? 4'h0 : (ew == W_DUAL) ? 4'h3 : 4'hF;
    // target and rate hold for the whole frame
    if (!in_frame) begin
      cur_tgt = t;
      cur_div = (t != TGT_TPM) ? 4'h3 : (rate == 2'h1) ? 4'h8 : (rate == 2'h2) ? 4'h4 :
        (rate == 2'h3) ? 4'h3 : 4'h7;
    end
    in_frame = !l;
    e.sel = ~(3'h1 << cur_tgt);
    e.div = cur_div;
    exp_q.push_back(e);
    m_width <= ew;
    m_resp <= e.rx;
    launch(t, w, r, l, e.tx);
    n = 0;
    while (ack !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("ack", 8'h1, 8'(ack));
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    req <= 1'b0;
    exp_q.delete();
    in_frame = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("rst_clk", 8'h1, 8'({sclk_oe, sclk_pd}));
    check("rst_sel", 8'h0, 8'({sel_oe, ready, ack}));
    check("rst_data_oe", 8'h0, 8'(d_oe));
    check("rst_pull", 8'hC, 8'(d_pu));
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("run_clk", 8'h4, 8'({sclk_oe, sclk, sclk_pd}));
    check("run_sel", 8'hF, 8'({sel_oe, sel_n}));
    check("run_data", 8'h2, 8'({d_oe, d_out[0]}));
    check("run_pull", 8'hE, 8'(d_pu));
    check("run_ready", 8'h1, 8'(ready));
  endtask

  // per byte: period, lanes, selects and shifted bits seen at each rise
  always @(posedge clk or negedge rst_n) begin
    sft_exp_t e;
    if (!rst_n) begin
      sclk_q = 1'b0;
    end else begin
      cyc++;
      if (sclk === 1'b1 && sclk_q !== 1'b1) begin
        per = cyc - t_rise;
        t_rise = cyc;
        sel_s = sel_n;
        oe_s = d_oe;
        col = (m_width == W_QUAD) ? {col[3:0], d_out} :
          (m_width == W_DUAL) ? {col[5:0], d_out[1:0]} : {col[6:0], d_out[0]};
      end
      sclk_q = sclk;
      if (ack === 1'b1 && exp_q.size() == 0) begin
        check("ack_unasked", 8'h0, 8'h1);
      end else if (ack === 1'b1) begin
        e = exp_q.pop_front();
        check("select", 8'(e.sel), 8'(sel_s));
        check("lane_oe", 8'(e.oe), 8'(oe_s));
        check("clk_div", 8'(e.div), 8'(per));
        if (e.chk_rx) check("rx_byte", e.rx, rx_byte);
        if (e.chk_tx) check("tx_byte", e.tx, col);
      end
    end
  end

  // longest run is some 23 bytes of under 70 cycles; wide margin kept
  initial begin
    #(200000);
    fail_count++;
    give_verdict();
  end

  initial begin
    seed = 32'hD8AC;
    do_reset();
    for (int t = 0; t < 3; t++) begin
      send(2'(t), W_SINGLE, 1'b0, 1'b0);
      send(2'(t), W_SINGLE, 1'b1, 1'b1);
    end
    send(TGT_PRIMARY, W_QUAD, 1'b1, 1'b1);
    // target code 3 must never open a frame
    @(posedge clk);
    req <= 1'b1;
    tgt <= 2'h3;
    repeat (20) @(posedge clk);
    check("refused_sel", 8'h7, 8'(sel_n));
    req <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      rate <= 2'(s);
      repeat (4) @(posedge clk);
      send(TGT_TPM, W_SINGLE, 1'b1, 1'b1);
      send(TGT_SECONDARY, W_SINGLE, 1'b0, 1'b1);
    end
    bidir <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      send(TGT_PRIMARY, (k < 2) ? W_DUAL : W_QUAD, k[0], 1'b0);
      send(TGT_PRIMARY, (k < 2) ? W_DUAL : W_QUAD, k[0], 1'b1);
    end
    // reset in mid-byte returns every pin to its reset state
    launch(TGT_TPM, W_SINGLE, 1'b1, 1'b1, 8'hA5);
    repeat (6) @(posedge clk);
    check("mid_sel", 8'h3, 8'(sel_n));
    do_reset();
    send(TGT_TPM, W_DUAL, 1'b1, 1'b1);
    give_verdict();
  end
endmodule // testbench
